// ---- hdl/epdo_pkg.sv ----
// Purpose: Constants and types shared by the divided pulse output logic.
// Assumes: 100 MHz system clock.
// Notes: Register indices are word addresses on the plain register port.
//
// How it works
// - Divided pulses leave on two paths, an open-collector pair and a differential port.
// - The open-collector pair carries divided encoder quadrature at no more than 3 kHz.
// - The differential port is driven only while the full-closed loop enable is 0.
// - Source select 0 sends encoder pulses, 1 forwards command pulses, 2 leaves the port as input.
// - Only encoder pulses are divided on the differential port; command pulses pass undivided.
// - The division factor runs from 1 to 65535; a larger factor gives a lower rate with an incremental encoder, a higher one with an absolute one.
// - With an incremental encoder one output pulse leaves for every N encoder pulses.
// - With an absolute encoder N pulses leave per revolution, plus one index pulse per turn.
// - The factor resets to 1 for an incremental encoder and to 10 for an absolute one.
// - Output polarity 0 is normal and 1 inverted, for encoder A and B pulses only; the index pulse has its own polarity.
// - Routing 0 gives generic functions, 1 gives encoder A and B, 2 gives index and generic.
// - Each encoder index event gives a 5 ms active pulse on the first open-collector output.
package epdo_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] EPDO_REG_SRC = 4'h0;
  localparam logic [3:0] EPDO_REG_FACTOR = 4'h1;
  localparam logic [3:0] EPDO_REG_POL = 4'h2;
  localparam logic [3:0] EPDO_REG_IDX_POL = 4'h3;
  localparam logic [3:0] EPDO_REG_ROUTE = 4'h4;
  localparam logic [3:0] EPDO_REG_FCL = 4'h5;
  localparam logic [3:0] EPDO_REG_STATUS = 4'h6;

  // Status bit positions
  localparam int EPDO_ST_ABS = 0;
  localparam int EPDO_ST_DIFF_DRV = 1;
  localparam int EPDO_ST_IDX_ACT = 2;

  // Reset values
  localparam logic [15:0] EPDO_SRC_RST = 16'h0000;
  localparam logic [15:0] EPDO_FACTOR_INC_RST = 16'h0001;
  localparam logic [15:0] EPDO_FACTOR_ABS_RST = 16'h000a;
  localparam logic [15:0] EPDO_POL_RST = 16'h0000;
  localparam logic [15:0] EPDO_IDX_POL_RST = 16'h0000;
  localparam logic [15:0] EPDO_ROUTE_RST = 16'h0000;
  localparam logic [15:0] EPDO_FCL_RST = 16'h0000;

  // Legal upper values of the selects
  localparam logic [15:0] EPDO_SRC_MAX = 16'h0002;
  localparam logic [15:0] EPDO_ROUTE_MAX = 16'h0002;
  localparam logic [15:0] EPDO_BIT_MAX = 16'h0001;

  // Encoder pulses per turn in absolute mode, four edges each, value arbitrary
  localparam logic [15:0] EPDO_ABS_COUNTS_PER_REV = 16'h2710;

  // ==========================================================
  // Timing
  localparam int EPDO_CLK_HZ = 100_000_000;
  localparam int EPDO_OC_MAX_HZ = 3000;
  localparam int EPDO_EDGES_PER_PULSE = 4;
  localparam int EPDO_OC_EDGE_CYC = (EPDO_CLK_HZ + EPDO_OC_MAX_HZ * EPDO_EDGES_PER_PULSE - 1)
    / (EPDO_OC_MAX_HZ * EPDO_EDGES_PER_PULSE);
  localparam int EPDO_IDX_WIDTH_MS = 5;
  localparam int EPDO_IDX_CYC = (EPDO_CLK_HZ / 1000) * EPDO_IDX_WIDTH_MS;

  // ==========================================================
  // Selects
  typedef enum logic [1:0] {
    EPDO_SRC_MOTOR,
    EPDO_SRC_CMD,
    EPDO_SRC_INPUT
  } epdo_src_t;

  typedef enum logic [1:0] {
    EPDO_ROUTE_GENERIC,
    EPDO_ROUTE_AB,
    EPDO_ROUTE_INDEX
  } epdo_route_t;

endpackage

// ---- hdl/epdo_div_if.sv ----
// Purpose: Carries divider settings, input edges and output steps.
// Assumes: Single clock domain.
// Notes: ctrl side is the top, div side the rate divider.
interface epdo_div_if;
  logic [15:0] inc;
  logic [15:0] modulus;
  logic restart;
  logic edge_in;
  logic step;
  modport ctrl (output inc, output modulus, output restart, output edge_in, input step);
  modport div (input inc, input modulus, input restart, input edge_in, output step);
endinterface

// ---- hdl/epdo_divider.sv ----
// Purpose: Rate divider giving one step per modulus/inc input edges.
// Assumes: modulus is never zero.
// Notes: Accumulates inc per edge and steps on reaching modulus.
module epdo_divider
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  epdo_div_if.div dv
);
  import epdo_pkg::*;

  logic [16:0] acc_q;
  logic [16:0] acc_d;
  logic step_q;
  logic step_d;
  logic [16:0] sum;

  always_comb
  begin
    sum = acc_q + {1'b0, dv.inc};
    acc_d = acc_q;
    step_d = 1'b0;
    if (dv.restart)
    begin
      acc_d = '0;
    end
    else if (dv.edge_in)
    begin
      if (sum >= {1'b0, dv.modulus})
      begin
        acc_d = sum - {1'b0, dv.modulus};
        step_d = 1'b1;
      end
      else
      begin
        acc_d = sum;
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      acc_q <= '0;
      step_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      step_q <= step_d;
    end
  end

  assign dv.step = step_q;
endmodule

// ---- hdl/epdo_stretch.sv ----
// Purpose: One-shot stretching a trigger into a fixed-width active level.
// Assumes: WIDTH of at least one cycle.
// Notes: A new trigger while active restarts the width.
module epdo_stretch
#(
  parameter int WIDTH = 1
)
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic trig_i,
  output logic active_o
);
  import epdo_pkg::*;

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic active_q;
  logic active_d;

  always_comb
  begin
    cnt_d = cnt_q;
    active_d = active_q;
    if (trig_i)
    begin
      cnt_d = 32'(WIDTH - 1);
      active_d = 1'b1;
    end
    else if (cnt_q != '0)
    begin
      cnt_d = cnt_q - 32'h1;
    end
    else
    begin
      active_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= '0;
      active_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      active_q <= active_d;
    end
  end

  assign active_o = active_q;
endmodule

// ---- hdl/epdo_top.sv ----
// Purpose: Divided encoder pulse output with open-collector and differential paths.
// Assumes: Encoder pins asynchronous; command pulses and generic levels on clock_i.
// Notes: Encoder type strap is caught in the first cycle after reset release.
module epdo_top
#(
  parameter int OC_EDGE_CYC = epdo_pkg::EPDO_OC_EDGE_CYC,
  parameter int IDX_CYC = epdo_pkg::EPDO_IDX_CYC
)
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_z_i,
  input wire logic enc_absolute_i,
  input wire logic cmd_pulse_i,
  input wire logic cmd_sign_i,
  input wire logic first_output_function_i,
  input wire logic second_output_function_i,
  output logic first_open_collector_output_o,
  output logic second_open_collector_output_o,
  output logic diff_a_o,
  output logic diff_b_o,
  output logic diff_oe_n_o
);
  import epdo_pkg::*;

  // ==========================================================
  // Registers
  logic [15:0] src_q, src_d;
  logic [15:0] factor_q, factor_d;
  logic [15:0] pol_q, pol_d;
  logic [15:0] idx_pol_q, idx_pol_d;
  logic [15:0] route_q, route_d;
  logic [15:0] fcl_q, fcl_d;
  logic [15:0] rdata_q, rdata_d;
  logic abs_q, abs_d;
  logic strap_done_q, strap_done_d;
  logic restart_q, restart_d;
  logic [15:0] status;
  logic diff_drive;
  logic idx_active;

  assign diff_drive = (fcl_q == 16'h0000) && (src_q != 16'(EPDO_SRC_INPUT));
  assign status = 16'({idx_active, diff_drive, abs_q});

  always_comb
  begin
    src_d = src_q;
    factor_d = factor_q;
    pol_d = pol_q;
    idx_pol_d = idx_pol_q;
    route_d = route_q;
    fcl_d = fcl_q;
    abs_d = abs_q;
    strap_done_d = 1'b1;
    restart_d = 1'b0;
    rdata_d = 16'h0000;
    if (!strap_done_q)
    begin
      abs_d = enc_absolute_i;
      factor_d = enc_absolute_i ? EPDO_FACTOR_ABS_RST : EPDO_FACTOR_INC_RST;
      restart_d = 1'b1;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        EPDO_REG_SRC:
        begin
          if (reg_wdata_i <= EPDO_SRC_MAX)
          begin
            src_d = reg_wdata_i;
            restart_d = 1'b1;
          end
        end
        EPDO_REG_FACTOR:
        begin
          if (reg_wdata_i != 16'h0000)
          begin
            factor_d = reg_wdata_i;
            restart_d = 1'b1;
          end
        end
        EPDO_REG_POL:
        begin
          if (reg_wdata_i <= EPDO_BIT_MAX)
          begin
            pol_d = reg_wdata_i;
          end
        end
        EPDO_REG_IDX_POL:
        begin
          if (reg_wdata_i <= EPDO_BIT_MAX)
          begin
            idx_pol_d = reg_wdata_i;
          end
        end
        EPDO_REG_ROUTE:
        begin
          if (reg_wdata_i <= EPDO_ROUTE_MAX)
          begin
            route_d = reg_wdata_i;
          end
        end
        EPDO_REG_FCL:
        begin
          if (reg_wdata_i <= EPDO_BIT_MAX)
          begin
            fcl_d = reg_wdata_i;
          end
        end
        default:
        begin
        end
      endcase
    end
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        EPDO_REG_SRC: rdata_d = src_q;
        EPDO_REG_FACTOR: rdata_d = factor_q;
        EPDO_REG_POL: rdata_d = pol_q;
        EPDO_REG_IDX_POL: rdata_d = idx_pol_q;
        EPDO_REG_ROUTE: rdata_d = route_q;
        EPDO_REG_FCL: rdata_d = fcl_q;
        EPDO_REG_STATUS: rdata_d = status;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      src_q <= EPDO_SRC_RST;
      factor_q <= EPDO_FACTOR_INC_RST;
      pol_q <= EPDO_POL_RST;
      idx_pol_q <= EPDO_IDX_POL_RST;
      route_q <= EPDO_ROUTE_RST;
      fcl_q <= EPDO_FCL_RST;
      abs_q <= 1'b0;
      strap_done_q <= 1'b0;
      restart_q <= 1'b1;
      rdata_q <= 16'h0000;
    end
    else
    begin
      src_q <= src_d;
      factor_q <= factor_d;
      pol_q <= pol_d;
      idx_pol_q <= idx_pol_d;
      route_q <= route_d;
      fcl_q <= fcl_d;
      abs_q <= abs_d;
      strap_done_q <= strap_done_d;
      restart_q <= restart_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Encoder pin synchroniser and quadrature decode
  logic [2:0] sync1_q, sync2_q, sync3_q;
  logic [2:0] enc_q, enc_d;
  logic [2:0] enc_prev_q;
  logic enc_edge;
  logic enc_fwd;
  logic z_rise;

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      enc_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : enc_q[i];
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      enc_q <= 3'h0;
      enc_prev_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {enc_z_i, enc_b_i, enc_a_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      enc_q <= enc_d;
      enc_prev_q <= enc_q;
    end
  end

  // Bit 0 is A, bit 1 is B, bit 2 is Z
  assign enc_edge = (enc_q[1:0] != enc_prev_q[1:0]);
  assign enc_fwd = enc_prev_q[0] ^ enc_q[1];
  assign z_rise = enc_q[2] & ~enc_prev_q[2];

  // ==========================================================
  // Rate divider
  epdo_div_if div_bus ();
  logic dir_q, dir_d;

  // Incremental counts edges against N, absolute spreads N steps per turn
  assign div_bus.inc = abs_q ? factor_q : 16'h0001;
  assign div_bus.modulus = abs_q ? EPDO_ABS_COUNTS_PER_REV : factor_q;
  assign div_bus.restart = restart_q;
  assign div_bus.edge_in = enc_edge;
  assign dir_d = enc_edge ? enc_fwd : dir_q;

  epdo_divider u_divider
  (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .dv(div_bus.div)
  );

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      dir_q <= 1'b1;
    end
    else
    begin
      dir_q <= dir_d;
    end
  end

  // ==========================================================
  // Open-collector quadrature, paced to the rate limit
  logic [1:0] oc_phase_q, oc_phase_d;
  logic signed [15:0] pend_q, pend_d;
  logic [31:0] pace_q, pace_d;

  always_comb
  begin
    oc_phase_d = oc_phase_q;
    pend_d = pend_q;
    pace_d = pace_q;
    if (restart_q)
    begin
      pend_d = 16'sh0000;
    end
    else if (div_bus.step)
    begin
      pend_d = dir_q ? pend_q + 16'sh0001 : pend_q - 16'sh0001;
    end
    if (pace_q != '0)
    begin
      pace_d = pace_q - 32'h1;
    end
    else if (pend_d != 16'sh0000)
    begin
      oc_phase_d = (pend_d > 16'sh0000) ? oc_phase_q + 2'h1 : oc_phase_q - 2'h1;
      pend_d = (pend_d > 16'sh0000) ? pend_d - 16'sh0001 : pend_d + 16'sh0001;
      pace_d = 32'(OC_EDGE_CYC - 1);
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      oc_phase_q <= 2'h0;
      pend_q <= 16'sh0000;
      pace_q <= '0;
    end
    else
    begin
      oc_phase_q <= oc_phase_d;
      pend_q <= pend_d;
      pace_q <= pace_d;
    end
  end

  // ==========================================================
  // Index pulse
  epdo_stretch #(.WIDTH(IDX_CYC)) u_index
  (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .trig_i(z_rise),
    .active_o(idx_active)
  );

  // ==========================================================
  // Differential quadrature and output stage
  logic [1:0] diff_phase_q, diff_phase_d;
  logic oc1_q, oc1_d, oc2_q, oc2_d;
  logic da_q, da_d, db_q, db_d, doe_n_q, doe_n_d;
  logic inv;

  assign inv = pol_q[0];

  always_comb
  begin
    diff_phase_d = diff_phase_q;
    if (div_bus.step)
    begin
      diff_phase_d = dir_q ? diff_phase_q + 2'h1 : diff_phase_q - 2'h1;
    end
    unique case (route_q[1:0])
      EPDO_ROUTE_AB:
      begin
        oc1_d = oc_phase_q[1] ^ inv;
        oc2_d = oc_phase_q[1] ^ oc_phase_q[0] ^ inv;
      end
      EPDO_ROUTE_INDEX:
      begin
        oc1_d = idx_active ^ idx_pol_q[0];
        oc2_d = second_output_function_i;
      end
      default:
      begin
        oc1_d = first_output_function_i;
        oc2_d = second_output_function_i;
      end
    endcase
    doe_n_d = ~diff_drive;
    if (src_q[1:0] == EPDO_SRC_CMD)
    begin
      da_d = cmd_pulse_i;
      db_d = cmd_sign_i;
    end
    else if (diff_drive)
    begin
      da_d = diff_phase_q[1] ^ inv;
      db_d = diff_phase_q[1] ^ diff_phase_q[0] ^ inv;
    end
    else
    begin
      da_d = 1'b0;
      db_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      diff_phase_q <= 2'h0;
      oc1_q <= 1'b0;
      oc2_q <= 1'b0;
      da_q <= 1'b0;
      db_q <= 1'b0;
      doe_n_q <= 1'b1;
    end
    else
    begin
      diff_phase_q <= diff_phase_d;
      oc1_q <= oc1_d;
      oc2_q <= oc2_d;
      da_q <= da_d;
      db_q <= db_d;
      doe_n_q <= doe_n_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign first_open_collector_output_o = oc1_q;
  assign second_open_collector_output_o = oc2_q;
  assign diff_a_o = da_q;
  assign diff_b_o = db_q;
  assign diff_oe_n_o = doe_n_q;
endmodule

// ---- sim/epdo_top_asserts.sv ----
// Purpose: Port checks for the divided pulse output block.
// Assumes: Shadows follow only the writes that the block accepts.
// Notes: Bound into every epdo_top.
module epdo_top_asserts
  import epdo_pkg::*;
#(
  parameter int OC_EDGE_CYC = 4,
  parameter int IDX_CYC = 20
)
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic cmd_pulse_i,
  input wire logic cmd_sign_i,
  input wire logic first_output_function_i,
  input wire logic second_output_function_i,
  input wire logic first_open_collector_output_o,
  input wire logic second_open_collector_output_o,
  input wire logic diff_a_o,
  input wire logic diff_b_o,
  input wire logic diff_oe_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] src_q, src_d, route_q, route_d, oc_q, oc;
  logic fcl_q, fcl_d, ipol_q, ipol_d, act;
  logic [15:0] gap_q, gap_d;
  logic [31:0] run_q, run_d;
  assign oc = {first_open_collector_output_o, second_open_collector_output_o};
  // First output at its active level
  assign act = first_open_collector_output_o ^ ipol_q;

  // ==========================================================
  // Shadows and counters
  always_comb
  begin
    src_d = src_q;
    route_d = route_q;
    fcl_d = fcl_q;
    ipol_d = ipol_q;
    if (reg_wr_i && reg_addr_i == EPDO_REG_SRC && reg_wdata_i <= EPDO_SRC_MAX)
      src_d = reg_wdata_i[1:0];
    if (reg_wr_i && reg_addr_i == EPDO_REG_ROUTE && reg_wdata_i <= EPDO_ROUTE_MAX)
      route_d = reg_wdata_i[1:0];
    if (reg_wr_i && reg_addr_i == EPDO_REG_FCL && reg_wdata_i <= EPDO_BIT_MAX)
      fcl_d = reg_wdata_i[0];
    if (reg_wr_i && reg_addr_i == EPDO_REG_IDX_POL && reg_wdata_i <= EPDO_BIT_MAX)
      ipol_d = reg_wdata_i[0];
    gap_d = (oc != oc_q) ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hffff};
    run_d = act ? run_q + 32'h1 : 32'h0;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      src_q <= 2'h0;
      route_q <= 2'h0;
      fcl_q <= 1'b0;
      ipol_q <= 1'b0;
      oc_q <= 2'h0;
      gap_q <= 16'hffff;
      run_q <= 32'h0;
    end
    else
    begin
      src_q <= src_d;
      route_q <= route_d;
      fcl_q <= fcl_d;
      ipol_q <= ipol_d;
      oc_q <= oc;
      gap_q <= gap_d;
      run_q <= run_d;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  oe_fcl_a: assert property (fcl_q [*3] |-> diff_oe_n_o)
    else $error("differential port driven with full closed loop on");
  oe_src_a: assert property ((src_q == 2'h2) [*3] |-> diff_oe_n_o)
    else $error("differential port driven while input selected");
  oe_drive_a: assert property ((src_q != 2'h2 && !fcl_q) [*3] |-> !diff_oe_n_o)
    else $error("differential port not driven");
  cmd_fwd_a: assert property ((src_q == 2'h1 && !fcl_q) [*3] |->
    diff_a_o == $past(cmd_pulse_i) && diff_b_o == $past(cmd_sign_i))
    else $error("command pulse not forwarded as is");
  generic_pass_a: assert property ((route_q == 2'h0) [*3] |->
    oc == $past({first_output_function_i, second_output_function_i}))
    else $error("generic levels not passed");
  route_index_a: assert property ((route_q == 2'h2) [*3] |->
    second_open_collector_output_o == $past(second_output_function_i))
    else $error("second output lost generic level");
  oc_gap_a: assert property (route_q == 2'h1 && $past(route_q) == 2'h1 && oc != oc_q
    |-> gap_q >= 16'(OC_EDGE_CYC - 1))
    else $error("open collector edges too close");
  index_width_a: assert property (route_q == 2'h2 && $past(route_q, 3) == 2'h2
    && ipol_q == $past(ipol_q, 3) && $past(act) && !act |-> run_q == 32'(IDX_CYC))
    else $error("index pulse width wrong");

  idx_c: cover property (route_q == 2'h2 && $past(act) && !act);
  cmd_c: cover property (src_q == 2'h1 && $rose(diff_a_o));
  oc_c: cover property (route_q == 2'h1 && oc != oc_q);
endmodule

bind epdo_top epdo_top_asserts #(.OC_EDGE_CYC(OC_EDGE_CYC), .IDX_CYC(IDX_CYC)) epdo_top_asserts_i (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .cmd_pulse_i(cmd_pulse_i),
  .cmd_sign_i(cmd_sign_i), .first_output_function_i(first_output_function_i),
  .second_output_function_i(second_output_function_i),
  .first_open_collector_output_o(first_open_collector_output_o),
  .second_open_collector_output_o(second_open_collector_output_o),
  .diff_a_o(diff_a_o), .diff_b_o(diff_b_o), .diff_oe_n_o(diff_oe_n_o));

// ---- sim/epdo_host_model.sv ----
// Purpose: Host controller counting divided pulse edges.
// Assumes: Pulses slow against the clock.
// Notes: A released port is not counted.
module epdo_host_model
(
  input wire logic clock_i,
  input wire logic a_i,
  input wire logic b_i,
  input wire logic released_i,
  output int edges_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  int cnt_q = 0;
  // Single driver for the count port
  assign edges_o = cnt_q;
  always @(posedge clock_i)
  begin
    if (!released_i)
      cnt_q <= cnt_q + int'(a_i !== a_q) + int'(b_i !== b_q);
    a_q <= a_i;
    b_q <= b_i;
  end
endmodule

// ---- sim/tb_top.sv ----
// Purpose: Register driven test of the divided pulse output block.
// Assumes: Short counts set through parameters.
// Notes: Host models count edges on both output paths.
module tb_top
  import epdo_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int IDX_SIM = 20;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0, rd_s = 1'b0, enc_a = 1'b0, enc_b = 1'b0, enc_z = 1'b0;
  logic enc_abs = 1'b0, cmd_p = 1'b0, cmd_s = 1'b0, gen1 = 1'b0, gen2 = 1'b0;
  logic [15:0] rdata;
  logic oc1, oc2, da, db, doe_n, pa;
  logic [1:0] ph = 2'h0;
  int fails = 0;
  int tests_run = 0;
  int diff_cnt, oc_cnt, c0;

  epdo_top #(.OC_EDGE_CYC(4), .IDX_CYC(IDX_SIM)) epdo_top_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .enc_a_i(enc_a), .enc_b_i(enc_b),
    .enc_z_i(enc_z), .enc_absolute_i(enc_abs), .cmd_pulse_i(cmd_p), .cmd_sign_i(cmd_s),
    .first_output_function_i(gen1), .second_output_function_i(gen2),
    .first_open_collector_output_o(oc1), .second_open_collector_output_o(oc2),
    .diff_a_o(da), .diff_b_o(db), .diff_oe_n_o(doe_n));
  epdo_host_model epdo_host_model_i (.clock_i(clock_i), .a_i(da), .b_i(db),
    .released_i(doe_n), .edges_o(diff_cnt));
  epdo_host_model oc_host_i (.clock_i(clock_i), .a_i(oc1), .b_i(oc2),
    .released_i(1'b0), .edges_o(oc_cnt));

  initial
    forever #5 clock_i = ~clock_i;

  // ==========================================================
  // Tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic do_reset(input logic abs_v);
    sys_rst_i <= 1'b1;
    enc_abs <= abs_v;
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  // Quadrature steps eight clocks apart
  task automatic enc_step(input int n);
    repeat (n)
    begin
      @(posedge clock_i);
      ph = ph + 2'h1;
      enc_a <= ph[1];
      enc_b <= ph[1] ^ ph[0];
      repeat (7) @(posedge clock_i);
    end
    repeat (24) @(posedge clock_i);
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    do_reset(1'b0);
    for (int i = 0; i < 6; i++)
      reg_read(4'(i), (i == 1) ? 16'h0001 : 16'h0000);
    reg_write(EPDO_REG_SRC, 16'h0003);
    reg_write(EPDO_REG_FACTOR, 16'h0000);
    reg_write(EPDO_REG_POL, 16'h0002);
    reg_write(EPDO_REG_ROUTE, 16'h0003);
    reg_write(EPDO_REG_STATUS, 16'hffff);
    reg_read(EPDO_REG_SRC, 16'h0000);
    reg_read(EPDO_REG_FACTOR, 16'h0001);
    reg_read(EPDO_REG_POL, 16'h0000);
    reg_read(EPDO_REG_ROUTE, 16'h0000);
    reg_read(EPDO_REG_STATUS, 16'h0002);
    reg_read(4'hf, 16'h0000);
    $display("test reset_refusal done");
    for (int n = 1; n <= 3; n++)
    begin
      reg_write(EPDO_REG_FACTOR, 16'(n));
      c0 = diff_cnt;
      enc_step(12 * n);
      check(16'(diff_cnt - c0), 16'h000c);
    end
    reg_write(EPDO_REG_FACTOR, 16'hffff);
    reg_read(EPDO_REG_FACTOR, 16'hffff);
    c0 = diff_cnt;
    enc_step(8);
    check(16'(diff_cnt - c0), 16'h0000);
    $display("test divide done");
    reg_write(EPDO_REG_FACTOR, 16'h0001);
    pa = da;
    reg_write(EPDO_REG_POL, 16'h0001);
    repeat (4) @(posedge clock_i);
    check(da ^ pa, 1'b1);
    reg_write(EPDO_REG_SRC, 16'h0001);
    cmd_p <= 1'b1;
    cmd_s <= 1'b1;
    repeat (4) @(posedge clock_i);
    check({db, da}, 2'h3);
    c0 = diff_cnt;
    enc_step(8);
    check(16'(diff_cnt - c0), 16'h0000);
    reg_write(EPDO_REG_SRC, 16'h0002);
    repeat (3) @(posedge clock_i);
    check(doe_n, 1'b1);
    reg_write(EPDO_REG_SRC, 16'h0000);
    reg_write(EPDO_REG_FCL, 16'h0001);
    repeat (3) @(posedge clock_i);
    check(doe_n, 1'b1);
    reg_read(EPDO_REG_STATUS, 16'h0000);
    reg_write(EPDO_REG_FCL, 16'h0000);
    repeat (3) @(posedge clock_i);
    check(doe_n, 1'b0);
    $display("test differential done");
    reg_write(EPDO_REG_POL, 16'h0000);
    reg_write(EPDO_REG_ROUTE, 16'h0001);
    reg_write(EPDO_REG_FACTOR, 16'h0002);
    repeat (4) @(posedge clock_i);
    c0 = oc_cnt;
    enc_step(16);
    check(16'(oc_cnt - c0), 16'h0008);
    pa = oc1;
    reg_write(EPDO_REG_POL, 16'h0001);
    repeat (3) @(posedge clock_i);
    check(oc1 ^ pa, 1'b1);
    reg_write(EPDO_REG_ROUTE, 16'h0000);
    gen1 <= 1'b1;
    repeat (3) @(posedge clock_i);
    check({oc1, oc2}, 2'h2);
    gen1 <= 1'b0;
    gen2 <= 1'b1;
    repeat (3) @(posedge clock_i);
    check({oc1, oc2}, 2'h1);
    reg_write(EPDO_REG_ROUTE, 16'h0002);
    repeat (3) @(posedge clock_i);
    gen1 <= 1'b1;
    repeat (3) @(posedge clock_i);
    check({oc1, oc2}, 2'h1);
    for (int ip = 0; ip < 2; ip++)
    begin
      reg_write(EPDO_REG_IDX_POL, 16'(ip));
      repeat (4) @(posedge clock_i);
      enc_z <= 1'b1;
      repeat (8) @(posedge clock_i);
      check(oc1, ip == 0);
      enc_z <= 1'b0;
      repeat (IDX_SIM + 4) @(posedge clock_i);
      check(oc1, ip != 0);
    end
    $display("test open_collector done");
    do_reset(1'b1);
    reg_read(EPDO_REG_FACTOR, 16'h000a);
    reg_read(EPDO_REG_STATUS, 16'h0003);
    reg_write(EPDO_REG_FACTOR, 16'h1388);
    c0 = diff_cnt;
    enc_step(16);
    check(16'(diff_cnt - c0), 16'(16 * 5000 / EPDO_ABS_COUNTS_PER_REV));
    $display("test absolute done");
    stop_test();
  end

  initial
  begin
    #300000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
